// ===== pkg/csbp_defs.svh
// constants for the codec stats and bin width serial port
`ifndef CSBP_DEFS_SVH
`define CSBP_DEFS_SVH
`define CSBP_WORD_W        16
`define CSBP_NUM_BANDS     42
`define CSBP_NUM_SUMS      3
`define CSBP_NUM_MAXMIN    6
`define CSBP_NUM_STATS     52
`define CSBP_NUM_BW        84
`define CSBP_STROBES_EVT   16
`define CSBP_PRESCALE      4
`define CSBP_CLK_NS        4
`define CSBP_FRAME_HZ      30
`define CSBP_FRAME_CYC     (1000000000 / (`CSBP_CLK_NS * `CSBP_FRAME_HZ))
`define CSBP_DEFAULT_BW    16'h0100
`endif

// ===== pkg/csbp_pkg.sv
// types for the codec stats and bin width serial port
package csbp_pkg;
	typedef enum logic [1:0] {
		CSBP_IDLE = 2'b00,
		CSBP_SEND = 2'b01,
		CSBP_RECV = 2'b10
	} csbp_dev_state_t;
	typedef enum logic [1:0] {
		CSBP_H_WAIT  = 2'b00,
		CSBP_H_RECV  = 2'b01,
		CSBP_H_WRITE = 2'b10
	} csbp_host_state_t;
endpackage : csbp_pkg

// ===== pkg/csbp_link_if.sv
// serial link between codec and signal processor
`timescale 1ns/1ps
`default_nettype none
interface csbp_link_if (input wire logic sclk);
	logic stats_ready_irq;
	logic tx_valid;
	logic tx_data;
	logic tx_last;
	logic rx_valid;
	logic rx_data;
	logic last_code_event;
	logic fifo_rd_strobe;
	modport codec (input sclk, output stats_ready_irq, output tx_valid, output tx_data, output tx_last,
		input rx_valid, input rx_data, output last_code_event, output fifo_rd_strobe);
	modport proc (input sclk, input stats_ready_irq, input tx_valid, input tx_data, input tx_last,
		output rx_valid, output rx_data, input last_code_event, input fifo_rd_strobe);
endinterface : csbp_link_if
`default_nettype wire

// ===== rtl/csbp_codec.sv
// codec end: stats sender, bin width receiver, last-code and fifo strobe
`timescale 1ns/1ps
`default_nettype none
`include "csbp_defs.svh"
module csbp_codec #(
	parameter int W = `CSBP_WORD_W
) (
	input  wire logic          REF_CLK_IN,
	input  wire logic          RESETN_IN,
	csbp_link_if.codec         LINK,
	input  wire logic          FIELD_DONE_IN,
	input  wire logic [W-1:0]  COMP_RATIO_IN,
	input  wire logic [W-1:0]  STAT_DATA_IN,
	output logic [5:0]         STAT_IDX_OUT,
	input  wire logic          HOST_FIFO_RD_IN,
	input  wire logic [1:0]    WORDS_LEFT_IN,
	input  wire logic [6:0]    BW_IDX_IN,
	output logic [W-1:0]       RECIP_BW_OUT,
	output logic [W-1:0]       BW_OUT,
	output logic               BW_DONE_OUT
);
	// link-domain logic; device runs on link clock, only FIELD_DONE_IN synchronised
	logic                      fd_s1_reg, fd_s2_reg, fd_s3_reg;
	csbp_pkg::csbp_dev_state_t state_reg;
	logic [6:0]                word_reg;
	logic [4:0]                bit_reg;
	logic [W-1:0]              sh_reg;
	logic [W-1:0]              rx_reg;
	logic [W-1:0]              bw_mem [0:`CSBP_NUM_BW-1];
	logic                      first_reg;
	logic                      done_s1_reg, done_s2_reg;
	logic                      done_lk_reg;
	wire logic                 word_end = (bit_reg == 5'(W - 1));
	wire logic                 start = fd_s2_reg & ~fd_s3_reg;

	always_ff @(posedge LINK.sclk or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			fd_s1_reg <= 1'b0;
			fd_s2_reg <= 1'b0;
			fd_s3_reg <= 1'b0;
		end else begin
			fd_s1_reg <= FIELD_DONE_IN;
			fd_s2_reg <= fd_s1_reg;
			fd_s3_reg <= fd_s2_reg;
		end
	end

	always_ff @(posedge LINK.sclk or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			state_reg   <= csbp_pkg::CSBP_IDLE;
			word_reg    <= 7'h00;
			bit_reg     <= 5'h00;
			sh_reg      <= '0;
			rx_reg      <= '0;
			done_lk_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				csbp_pkg::CSBP_IDLE: begin
					if (start) begin
						state_reg   <= csbp_pkg::CSBP_SEND;
						word_reg    <= 7'h00;
						bit_reg     <= 5'h00;
						done_lk_reg <= 1'b0;
						sh_reg      <= COMP_RATIO_IN;
					end
				end
				csbp_pkg::CSBP_SEND: begin
					bit_reg <= word_end ? 5'h00 : bit_reg + 5'h01;
					sh_reg  <= {sh_reg[W-2:0], 1'b0};
					if (word_end) begin
						if (word_reg == 7'(`CSBP_NUM_STATS - 1)) begin
							state_reg <= csbp_pkg::CSBP_RECV;
							word_reg  <= 7'h00;
						end else begin
							word_reg <= word_reg + 7'h01;
							sh_reg   <= STAT_DATA_IN;
						end
					end
				end
				csbp_pkg::CSBP_RECV: begin
					if (LINK.rx_valid) begin
						bit_reg <= word_end ? 5'h00 : bit_reg + 5'h01;
						rx_reg  <= {rx_reg[W-2:0], LINK.rx_data};
						if (word_end && word_reg == 7'(`CSBP_NUM_BW - 1)) begin
							state_reg   <= csbp_pkg::CSBP_IDLE;
							done_lk_reg <= 1'b1;
						end else if (word_end) begin
							word_reg <= word_reg + 7'h01;
						end
					end
				end
				default: state_reg <= csbp_pkg::CSBP_IDLE;
			endcase
		end
	end

	always_ff @(posedge LINK.sclk) begin
		if (state_reg == csbp_pkg::CSBP_RECV && LINK.rx_valid && word_end)
			bw_mem[word_reg] <= {rx_reg[W-2:0], LINK.rx_data};
	end

	// stat index: 0 ratio, 1..42 squares, then sums, then maxmin
	assign STAT_IDX_OUT = 6'(word_reg + 7'h01);
	assign LINK.stats_ready_irq = (state_reg == csbp_pkg::CSBP_SEND) && (word_reg == 7'h00) && (bit_reg == 5'h00);
	assign LINK.tx_valid = (state_reg == csbp_pkg::CSBP_SEND);
	assign LINK.tx_data  = sh_reg[W-1];
	assign LINK.tx_last  = LINK.tx_valid && word_end && (word_reg == 7'(`CSBP_NUM_STATS - 1));

	// user side reads quantizer table after crossing done flag
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			done_s1_reg <= 1'b0;
			done_s2_reg <= 1'b0;
		end else begin
			done_s1_reg <= done_lk_reg;
			done_s2_reg <= done_s1_reg;
		end
	end
	assign BW_DONE_OUT = done_s2_reg;
	// table is stable while idle, so a plain read after done is safe
	always_ff @(posedge REF_CLK_IN) begin
		RECIP_BW_OUT <= bw_mem[{BW_IDX_IN[5:0], 1'b0}];
		BW_OUT       <= bw_mem[{BW_IDX_IN[5:0], 1'b1}];
	end

	// host fifo side, on REF_CLK_IN like the user side
	logic lc_reg;
	logic strobe_reg;
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			lc_reg     <= 1'b0;
			strobe_reg <= 1'b0;
			first_reg  <= 1'b1;
		end else begin
			strobe_reg <= HOST_FIFO_RD_IN;
			if (done_s2_reg)
				first_reg <= 1'b0;
			// set at next-to-last, clear at last
			// no last code before the first bin width table is done
			if (HOST_FIFO_RD_IN && WORDS_LEFT_IN == 2'h2 && !first_reg)
				lc_reg <= 1'b1;
			else if (HOST_FIFO_RD_IN && WORDS_LEFT_IN == 2'h1)
				lc_reg <= 1'b0;
		end
	end
	assign LINK.last_code_event = lc_reg;
	assign LINK.fifo_rd_strobe  = strobe_reg;
endmodule : csbp_codec
`default_nettype wire

// ===== rtl/csbp_proc.sv
// processor end: stats capture, bin width send, field size, watchdog
`timescale 1ns/1ps
`default_nettype none
`include "csbp_defs.svh"
module csbp_proc #(
	parameter int W        = `CSBP_WORD_W,
	parameter int FRAME_CYC = `CSBP_FRAME_CYC
) (
	input  wire logic          REF_CLK_IN,
	input  wire logic          RESETN_IN,
	csbp_link_if.proc          LINK,
	input  wire logic [W-1:0]  BW_WORD_IN,
	output logic [6:0]         BW_IDX_OUT,
	output logic [W-1:0]       COMP_RATIO_OUT,
	output logic               STATS_DONE_OUT,
	output logic [15:0]        FIELD_SIZE_OUT,
	output logic               FIELD_SIZE_VALID_OUT,
	output logic               VIDEO_STOPPED_OUT
);
	csbp_pkg::csbp_host_state_t state_reg;
	logic [6:0]   word_reg;
	logic [4:0]   bit_reg;
	logic [W-1:0] sh_reg;
	logic [W-1:0] tx_reg;
	logic         sd_reg;
	wire logic    word_end = (bit_reg == 5'(W - 1));

	always_ff @(posedge LINK.sclk or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			state_reg      <= csbp_pkg::CSBP_H_WAIT;
			word_reg       <= 7'h00;
			bit_reg        <= 5'h00;
			sh_reg         <= '0;
			tx_reg         <= '0;
			COMP_RATIO_OUT <= '0;
			sd_reg         <= 1'b0;
		end else begin
			unique case (state_reg)
				csbp_pkg::CSBP_H_WAIT: begin
					if (LINK.stats_ready_irq) begin
						state_reg <= csbp_pkg::CSBP_H_RECV;
						sh_reg    <= {sh_reg[W-2:0], LINK.tx_data};
						bit_reg   <= 5'h01;
						word_reg  <= 7'h00;
					end
				end
				csbp_pkg::CSBP_H_RECV: begin
					if (LINK.tx_valid) begin
						bit_reg <= word_end ? 5'h00 : bit_reg + 5'h01;
						sh_reg  <= {sh_reg[W-2:0], LINK.tx_data};
						if (word_end && word_reg == 7'h00)
							COMP_RATIO_OUT <= {sh_reg[W-2:0], LINK.tx_data};
						if (word_end)
							word_reg <= word_reg + 7'h01;
						if (LINK.tx_last) begin
							state_reg <= csbp_pkg::CSBP_H_WRITE;
							word_reg  <= 7'h00;
							bit_reg   <= 5'h00;
							tx_reg    <= BW_WORD_IN;
							sd_reg    <= ~sd_reg;
						end
					end
				end
				csbp_pkg::CSBP_H_WRITE: begin
					bit_reg <= word_end ? 5'h00 : bit_reg + 5'h01;
					tx_reg  <= {tx_reg[W-2:0], 1'b0};
					if (word_end) begin
						if (word_reg == 7'(`CSBP_NUM_BW - 1)) begin
							state_reg <= csbp_pkg::CSBP_H_WAIT;
						end else begin
							word_reg <= word_reg + 7'h01;
							tx_reg   <= BW_WORD_IN;
						end
					end
				end
				default: state_reg <= csbp_pkg::CSBP_H_WAIT;
			endcase
		end
	end
	// index order recip then bin width
	assign BW_IDX_OUT   = (state_reg == csbp_pkg::CSBP_H_WRITE && word_end) ? word_reg + 7'h01 : 7'h00;
	assign LINK.rx_valid = (state_reg == csbp_pkg::CSBP_H_WRITE);
	assign LINK.rx_data  = tx_reg[W-1];

	// stats-done toggle into system clock
	logic sd_s1_reg, sd_s2_reg, sd_s3_reg;
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			sd_s1_reg <= 1'b0;
			sd_s2_reg <= 1'b0;
			sd_s3_reg <= 1'b0;
		end else begin
			sd_s1_reg <= sd_reg;
			sd_s2_reg <= sd_s1_reg;
			sd_s3_reg <= sd_s2_reg;
		end
	end
	assign STATS_DONE_OUT = sd_s2_reg ^ sd_s3_reg;

	// field size: strobes and last code are pins, so synchronised first
	logic rd_s1_reg, rd_s2_reg, rd_s3_reg;
	logic lc_s1_reg, lc_s2_reg, lc_s3_reg;
	logic [1:0]  pre_reg;
	logic [3:0]  div16_reg;
	logic [15:0] evt_reg;
	logic [1:0]  fields_idle_reg;
	logic [31:0] tick_reg;
	wire logic   rd_edge = rd_s2_reg & ~rd_s3_reg;
	wire logic   lc_edge = lc_s2_reg & ~lc_s3_reg;
	wire logic   tick    = (tick_reg == 32'(FRAME_CYC - 1));

	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			rd_s1_reg <= 1'b0;
			rd_s2_reg <= 1'b0;
			rd_s3_reg <= 1'b0;
			lc_s1_reg <= 1'b0;
			lc_s2_reg <= 1'b0;
			lc_s3_reg <= 1'b0;
		end else begin
			rd_s1_reg <= LINK.fifo_rd_strobe;
			rd_s2_reg <= rd_s1_reg;
			rd_s3_reg <= rd_s2_reg;
			lc_s1_reg <= LINK.last_code_event;
			lc_s2_reg <= lc_s1_reg;
			lc_s3_reg <= lc_s2_reg;
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			pre_reg              <= 2'h0;
			div16_reg            <= 4'h0;
			evt_reg              <= 16'h0000;
			FIELD_SIZE_OUT       <= 16'h0000;
			FIELD_SIZE_VALID_OUT <= 1'b0;
		end else begin
			FIELD_SIZE_VALID_OUT <= lc_edge;
			if (rd_edge)
				pre_reg <= pre_reg + 2'h1;
			if (rd_edge && pre_reg == 2'(`CSBP_PRESCALE - 1))
				div16_reg <= div16_reg + 4'h1;
			if (lc_edge) begin
				FIELD_SIZE_OUT <= evt_reg;
				// an event in the handover cycle opens the next count
				evt_reg        <= {15'h0000, rd_edge && pre_reg == 2'(`CSBP_PRESCALE - 1) && div16_reg == 4'hF};
			end else if (rd_edge && pre_reg == 2'(`CSBP_PRESCALE - 1) && div16_reg == 4'hF) begin
				evt_reg <= evt_reg + 16'h0001;
			end
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			tick_reg          <= 32'h0000_0000;
			fields_idle_reg   <= 2'h0;
			VIDEO_STOPPED_OUT <= 1'b0;
		end else begin
			tick_reg <= tick ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
			// an event in the tick cycle wins over the idle count
			if (lc_edge) begin
				fields_idle_reg   <= 2'h0;
				VIDEO_STOPPED_OUT <= 1'b0;
			end else if (tick) begin
				if (fields_idle_reg == 2'h2)
					VIDEO_STOPPED_OUT <= 1'b1;
				else
					fields_idle_reg <= fields_idle_reg + 2'h1;
			end
		end
	end
endmodule : csbp_proc
`default_nettype wire

// ===== testbench/csbp_link_checker.sv
// assertions on the codec to processor serial link
`timescale 1ns/1ps
`default_nettype none
module csbp_link_checker (
	input wire logic REF_CLK_IN,
	input wire logic RESETN_IN,
	input wire logic sclk,
	input wire logic stats_ready_irq,
	input wire logic tx_valid,
	input wire logic tx_last,
	input wire logic rx_valid,
	input wire logic last_code_event,
	input wire logic fifo_rd_strobe
);
	logic [10:0] tx_cnt_reg;
	logic [10:0] rx_cnt_reg;
	// run lengths in bits, too long for a repetition
	always_ff @(posedge sclk or negedge RESETN_IN) begin
		if (!RESETN_IN) tx_cnt_reg <= 11'h000;
		else tx_cnt_reg <= tx_valid ? tx_cnt_reg + 11'h001 : 11'h000;
	end
	always_ff @(posedge sclk or negedge RESETN_IN) begin
		if (!RESETN_IN) rx_cnt_reg <= 11'h000;
		else rx_cnt_reg <= rx_valid ? rx_cnt_reg + 11'h001 : 11'h000;
	end
	a_irq_opens_send: assert property (@(posedge sclk) disable iff (!RESETN_IN)
		$rose(tx_valid) |-> stats_ready_irq) else $error("send began without irq");
	a_irq_one_pulse: assert property (@(posedge sclk) disable iff (!RESETN_IN)
		stats_ready_irq |=> !stats_ready_irq) else $error("irq longer than one bit");
	a_send_length: assert property (@(posedge sclk) disable iff (!RESETN_IN)
		$fell(tx_valid) |-> tx_cnt_reg == 11'h340) else $error("stats send length wrong");
	a_last_then_recv: assert property (@(posedge sclk) disable iff (!RESETN_IN)
		tx_last |-> tx_valid ##1 (!tx_valid && rx_valid)) else $error("receive not after last stats bit");
	a_recv_length: assert property (@(posedge sclk) disable iff (!RESETN_IN)
		$fell(rx_valid) |-> rx_cnt_reg == 11'h540) else $error("bin width length wrong");
	a_one_way_only: assert property (@(posedge sclk) disable iff (!RESETN_IN)
		!(tx_valid && rx_valid)) else $error("both directions active");
	a_no_irq_recv: assert property (@(posedge sclk) disable iff (!RESETN_IN)
		rx_valid |-> !stats_ready_irq) else $error("irq during bin width receive");
	a_last_code_event_on_read: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		$changed(last_code_event) |-> (fifo_rd_strobe || $past(fifo_rd_strobe))) else $error("last code off a read");
	c_irq: cover property (@(posedge sclk) disable iff (!RESETN_IN) stats_ready_irq);
	c_table: cover property (@(posedge sclk) disable iff (!RESETN_IN) $fell(rx_valid));
	c_last_code_event: cover property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN) $rose(last_code_event));
endmodule : csbp_link_checker
`default_nettype wire

// ===== testbench/codec_stats_binwidth_port_bench.sv
// bench joining codec and processor ends over the link
`timescale 1ns/1ps
`default_nettype none
module codec_stats_binwidth_port_bench;
	logic        clk = 1'b0;
	logic        sclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        fd = 1'b0;
	logic        rd = 1'b0;
	logic [1:0]  left = 2'h3;
	logic [6:0]  bidx = 7'h00;
	logic [15:0] ratio = 16'h00FF;
	logic [15:0] got = 16'hFFFF;
	logic [15:0] sh = 16'h0000;
	logic [5:0]  sidx;
	logic [6:0]  pidx;
	logic [15:0] rbw, bw, cr, fsz;
	logic        bdone, sdone, fval, stop;
	int          err_count = 0, num_checks = 0, nbit = 0, nw = 0;
	always #2 clk = ~clk;
	// odd offset keeps the link clock out of phase
	initial #37 forever #80 sclk = ~sclk;
	csbp_link_if link_inst (.sclk(sclk));
	csbp_codec csbp_codec_inst (.REF_CLK_IN(clk), .RESETN_IN(rst_n), .LINK(link_inst), .FIELD_DONE_IN(fd),
		.COMP_RATIO_IN(ratio), .STAT_DATA_IN({10'h290, sidx}), .STAT_IDX_OUT(sidx), .HOST_FIFO_RD_IN(rd),
		.WORDS_LEFT_IN(left), .BW_IDX_IN(bidx), .RECIP_BW_OUT(rbw), .BW_OUT(bw), .BW_DONE_OUT(bdone));
	csbp_proc #(.FRAME_CYC(200)) csbp_proc_inst (.REF_CLK_IN(clk), .RESETN_IN(rst_n), .LINK(link_inst),
		.BW_WORD_IN({9'h180, pidx}), .BW_IDX_OUT(pidx), .COMP_RATIO_OUT(cr), .STATS_DONE_OUT(sdone),
		.FIELD_SIZE_OUT(fsz), .FIELD_SIZE_VALID_OUT(fval), .VIDEO_STOPPED_OUT(stop));
	csbp_link_checker csbp_link_checker_inst (.REF_CLK_IN(clk), .RESETN_IN(rst_n), .sclk(sclk),
		.stats_ready_irq(link_inst.stats_ready_irq), .tx_valid(link_inst.tx_valid), .tx_last(link_inst.tx_last),
		.rx_valid(link_inst.rx_valid), .last_code_event(link_inst.last_code_event),
		.fifo_rd_strobe(link_inst.fifo_rd_strobe));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wait_hi(ref logic s, input int lim);
		for (int i = 0; i < lim; i++) begin
			@(negedge clk);
			if (s === 1'b1) return;
		end
		chk(16'h0000, 16'h0001);
	endtask : wait_hi
	// words off the wire, msb first, mid-bit sampling
	always @(negedge sclk) begin
		if (link_inst.tx_valid === 1'b1 || link_inst.rx_valid === 1'b1) begin
			sh = {sh[14:0], link_inst.tx_valid ? link_inst.tx_data : link_inst.rx_data};
			nbit++;
			if (nbit % 16 == 0) begin
				if (link_inst.tx_valid) chk(sh, nw == 0 ? ratio : {10'h290, nw[5:0]});
				else chk(sh, {9'h180, 7'(nw - 52)});
				nw++;
			end
		end
	end
	always @(negedge clk) begin
		if (fval === 1'b1) got = fsz;
	end
	task automatic t_field;
		@(negedge clk);
		fd = 1'b1;
		wait_hi(sdone, 40000);
		chk(cr, ratio);
		chk(16'(nw), 16'h0034);
		wait_hi(bdone, 60000);
		chk(16'(nw), 16'h0088);
		for (int i = 0; i < 42; i++) begin
			@(negedge clk);
			bidx = 7'(i);
			repeat (3) @(negedge clk);
			chk(rbw, {9'h180, 7'(2 * i)});
			chk(bw, {9'h180, 7'(2 * i + 1)});
		end
	endtask : t_field
	// low gap of three cycles lets the edge detector see each strobe
	task automatic t_size(input int n, input logic [15:0] e);
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			rd = 1'b1;
			left = (i == n - 2) ? 2'h2 : (i == n - 1) ? 2'h1 : 2'h3;
			repeat (2) @(negedge clk);
			rd = 1'b0;
			repeat (2) @(negedge clk);
		end
		left = 2'h3;
		chk(got, e);
	endtask : t_size
	task automatic t_dog;
		repeat (150) @(negedge clk);
		chk(16'(stop), 16'h0000);
		repeat (900) @(negedge clk);
		chk(16'(stop), 16'h0001);
	endtask : t_dog
	task automatic print_verdict;
		if (err_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	// one exchange is about 87k cycles, the rest under 3k
	initial begin
		repeat (98000) @(posedge clk);
		err_count++;
		print_verdict;
	end
	initial begin
		repeat (4) @(negedge clk);
		repeat (2) @(posedge sclk);
		@(negedge clk);
		rst_n = 1'b1;
		repeat (150) @(negedge clk);
		t_field;
		t_size(130, 16'h0002);
		t_size(66, 16'h0001);
		t_dog;
		print_verdict;
	end
endmodule : codec_stats_binwidth_port_bench
`default_nettype wire
